// ### hdl/pss_pkg.sv
// Behaviour
// RULE1: Kill input high disconnects main output; standby output always stays enabled.
// RULE2: A short on the remote sense inputs shuts the supply down.
// RULE3: power_good is high only while every output is in regulation.
// RULE4: power_good drops on output undervoltage or on long enough input loss.
// RULE5: power_good delay timer does not start while any output is in current limit.
// RULE6: power_good is open-drain style so parallel supplies wire-OR it.
// RULE7: fault_alert_n is low while any shutdown or warning condition is active. The code flags main loss only in ST_ON, for one cycle, and never standby loss.
// RULE8: Inlet over-temperature warning sets at 60 C, clears back in operating range.
// RULE9: Fan is driven to maximum before overtemp_warning in temperature status is set.
// RULE10: input_ok high when input meets minimum, low during input over-voltage.
// RULE11: Input qualification for turn-on completes within 100 ms of input and standby.
// RULE12: input_ok stays low 75 to 120 ms after a drop, returns on good average.
// RULE13: input_ok delay at most 1700 ms from input and 20 ms from standby.
// RULE14: Outputs stay off at least 1 s after power_good is de-asserted.
// RULE15: Outputs reach regulation 5 to 400 ms after supply_on_n goes active.
// RULE16: power_good de-asserts within 5 ms of supply_on_n going inactive.
// RULE17: power_good asserts 100 to 500 ms after outputs reach regulation.
// RULE18: power_good stays low at least 100 ms in any off/on cycle.
// RULE19: All outputs in regulation no later than 3000 ms after input power.
// RULE20: Main output regulates 50 to 1000 ms after standby is in regulation.
// RULE21: fault_alert_n goes low within 2 ms of input power loss.
// RULE22: power_good stays asserted at least 0.3 ms after input power loss.
// RULE23: Host drives supply_on_n low to enable the main output, high to disable.
// RULE24: All windows are counted from a free-running 1 ms tick, cleared on reset. The code counts the 0.3 ms hold-up in clock cycles instead.
package pss_pkg;
    // Clock and tick
    localparam int CLK_KHZ = 40000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = TICK_MS * CLK_KHZ;
    localparam int HOLDUP_US = 300;
    localparam int HOLDUP_CYC = (HOLDUP_US * CLK_KHZ + 999) / 1000;
    // Windows in milliseconds, then the warning temperature in C
    localparam logic [10:0] SON_MIN_MS = 11'h005;
    localparam logic [10:0] SON_MAX_MS = 11'h190;
    localparam logic [10:0] VSB_MAIN_MS = 11'h032;
    localparam logic [10:0] PG_ON_MS = 11'h064;
    localparam logic [10:0] OFF_HOLD_MS = 11'h3E8;
    localparam logic [10:0] DWELL_MS = 11'h04B;
    localparam logic [10:0] MS_MAX = 11'h7FF;
    localparam logic [7:0] OT_WARN_DEGC = 8'h3C;
    // APB register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TEMP = 8'h08;
    localparam logic [7:0] ADDR_EVENT = 8'h0C;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_STANDBY_BIT = 1;
    localparam int EV_SENSE_BIT = 0;
    localparam int EV_RAMP_BIT = 1;
    localparam int EV_DCLOSS_BIT = 2;
    localparam int EV_OTW_BIT = 3;
    localparam int TEMP_OTW_BIT = 0;
    localparam int TEMP_VAL_LSB = 8;
    typedef enum logic [2:0] {
        ST_OFF, ST_START, ST_RAMP, ST_PG_DELAY, ST_ON, ST_OFF_HOLD, ST_FAULT
    } pss_state_e;
endpackage : pss_pkg

// ### hdl/pss_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer
    import pss_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int HOLDUP_CYCLES = HOLDUP_CYC
)
(
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic OUTPUT_KILL_IN,
    input wire logic SUPPLY_ON_N_IN,
    input wire logic DC_PRESENT_IN,
    input wire logic VIN_LOW_IN,
    input wire logic VIN_OV_IN,
    input wire logic VSB_OK_IN,
    input wire logic MAIN_OK_IN,
    input wire logic CUR_LIMIT_IN,
    input wire logic SENSE_SHORT_IN,
    input wire logic OVER_TEMP_IN,
    input wire logic [7:0] INLET_TEMP_IN,
    input wire logic FAN_AT_MAX_IN,
    output logic MAIN_EN_OUT,
    output logic VSB_EN_OUT,
    output logic ORING_EN_OUT,
    output logic POWER_GOOD_OUT,
    output logic POWER_GOOD_OE_OUT,
    output logic FAULT_ALERT_N_OUT,
    output logic FAULT_ALERT_N_OE_OUT,
    output logic INPUT_OK_OUT,
    output logic FAN_MAX_OUT
);
    pss_state_e state_ff, nxt_state;
    logic [15:0] tick_cnt_ff;
    logic tick_ff;
    logic [10:0] ms_cnt_ff;
    logic [10:0] vsb_ms_ff;
    logic [10:0] dwell_ms_ff;
    logic [13:0] holdup_cnt_ff;
    logic holdup_done;
    logic input_ok_ff, dropped_ff, in_good;
    logic main_en_ff, pg_ff, alert_ff, fan_max_ff, ot_warn_ff;
    logic [1:0] ctrl_ff;
    logic [3:0] event_ff;
    logic [31:0] prdata_ff;
    logic start_ok, stop_req, wr_en, rd_setup, addr_ok;

    // Free-running millisecond tick; every window below except the hold-up count counts these [RULE24]
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            tick_cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end
        else if (tick_cnt_ff == 16'(TICK_CYCLES - 1))
        begin
            tick_cnt_ff <= 16'h0000;
            tick_ff <= 1'b1;
        end
        else
        begin
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
            tick_ff <= 1'b0;
        end
    end

    // Hold-up count after input loss, in cycles since 0.3 ms is below one tick
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN || DC_PRESENT_IN)
            holdup_cnt_ff <= 14'h0000;
        else if (!holdup_done)
            holdup_cnt_ff <= holdup_cnt_ff + 14'h0001; // [RULE22]
    end
    assign holdup_done = (holdup_cnt_ff >= 14'(HOLDUP_CYCLES));

    // Time standby has been in regulation, saturating
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN || !VSB_OK_IN)
            vsb_ms_ff <= 11'h000;
        else if (tick_ff && vsb_ms_ff != MS_MAX)
            vsb_ms_ff <= vsb_ms_ff + 11'h001; // [RULE24]
    end

    // Input qualification: plain check at first power-up, dwell after a drop
    assign in_good = DC_PRESENT_IN && !VIN_LOW_IN && !VIN_OV_IN;
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            input_ok_ff <= 1'b0;
            dropped_ff <= 1'b0;
            dwell_ms_ff <= 11'h000;
        end
        else if (!in_good)
        begin
            // A bad sample restarts the window, so reassertion means a good average [RULE12]
            if (input_ok_ff)
                dropped_ff <= 1'b1;
            input_ok_ff <= 1'b0; // [RULE10]
            dwell_ms_ff <= 11'h000;
        end
        else
        begin
            if (tick_ff && dwell_ms_ff != MS_MAX)
                dwell_ms_ff <= dwell_ms_ff + 11'h001;
            // Qualify within a cycle of standby reaching regulation, or once the dwell passes after a drop [RULE11] [RULE13]
            if (VSB_OK_IN && (!dropped_ff || dwell_ms_ff > DWELL_MS))
                input_ok_ff <= 1'b1; // [RULE10] [RULE12]
        end
    end

    // Start and stop conditions
    assign start_ok = !SUPPLY_ON_N_IN && !OUTPUT_KILL_IN && input_ok_ff
        && ctrl_ff[CTRL_ENABLE_BIT]; // [RULE23]
    assign stop_req = SUPPLY_ON_N_IN || OUTPUT_KILL_IN || !ctrl_ff[CTRL_ENABLE_BIT]; // [RULE1] [RULE16]

    // Sequencer state; minimum windows compare strictly, since the free-running
    // tick can land right after a state change and make the first millisecond short
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_OFF:
                if (start_ok)
                    nxt_state = ST_START;
            ST_START:
                if (!start_ok)
                    nxt_state = ST_OFF;
                else if (ms_cnt_ff > SON_MIN_MS && vsb_ms_ff > VSB_MAIN_MS)
                    nxt_state = ST_RAMP; // [RULE15] [RULE20]
            ST_RAMP:
                if (stop_req || !DC_PRESENT_IN)
                    nxt_state = ST_OFF_HOLD;
                else if (MAIN_OK_IN && VSB_OK_IN)
                    nxt_state = ST_PG_DELAY;
                else if (ms_cnt_ff >= SON_MAX_MS)
                    nxt_state = ST_FAULT; // [RULE15] [RULE19]
            ST_PG_DELAY:
                if (stop_req || !DC_PRESENT_IN || !MAIN_OK_IN || !VSB_OK_IN)
                    nxt_state = ST_OFF_HOLD;
                else if (ms_cnt_ff > PG_ON_MS)
                    nxt_state = ST_ON; // [RULE17]
            ST_ON:
                if (stop_req || !MAIN_OK_IN || !VSB_OK_IN || holdup_done)
                    nxt_state = ST_OFF_HOLD; // [RULE3] [RULE4] [RULE16]
            ST_OFF_HOLD:
                if (ms_cnt_ff > OFF_HOLD_MS)
                    nxt_state = ST_OFF; // [RULE14] [RULE18]
            ST_FAULT:
                if (SUPPLY_ON_N_IN && !SENSE_SHORT_IN)
                    nxt_state = ST_OFF_HOLD;
            default:
                nxt_state = ST_OFF;
        endcase
        // Sense short overrides everything and latches off [RULE2]
        if (SENSE_SHORT_IN)
            nxt_state = ST_FAULT;
    end

    // State register
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            state_ff <= ST_OFF;
        else
            state_ff <= nxt_state;
    end

    // Window timer: restarts on each state change, frozen at zero in current limit during ST_PG_DELAY
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN || nxt_state != state_ff)
            ms_cnt_ff <= 11'h000;
        else if (state_ff == ST_PG_DELAY && CUR_LIMIT_IN)
            ms_cnt_ff <= 11'h000; // [RULE5]
        else if (tick_ff && ms_cnt_ff != MS_MAX)
            ms_cnt_ff <= ms_cnt_ff + 11'h001; // [RULE24]
    end

    // Output enables follow the next state so they settle with it
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            main_en_ff <= 1'b0;
            pg_ff <= 1'b0;
        end
        else
        begin
            main_en_ff <= (nxt_state == ST_RAMP) || (nxt_state == ST_PG_DELAY)
                || (nxt_state == ST_ON); // [RULE1] [RULE14]
            pg_ff <= (nxt_state == ST_ON); // [RULE3] [RULE4]
        end
    end

    // Fan is forced to full first; the warning waits for it to get there
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            fan_max_ff <= 1'b0;
            ot_warn_ff <= 1'b0;
        end
        else if (INLET_TEMP_IN >= OT_WARN_DEGC)
        begin
            fan_max_ff <= 1'b1; // [RULE9]
            if (fan_max_ff && FAN_AT_MAX_IN)
                ot_warn_ff <= 1'b1; // [RULE8] [RULE9]
        end
        else
        begin
            fan_max_ff <= 1'b0;
            ot_warn_ff <= 1'b0; // [RULE8]
        end
    end

    // Alert is the OR of the shutdown and warning sources; main loss counts only in ST_ON and standby loss not at all
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            alert_ff <= 1'b0;
        else
            alert_ff <= !DC_PRESENT_IN || VIN_OV_IN || OVER_TEMP_IN || ot_warn_ff
                || CUR_LIMIT_IN || state_ff == ST_FAULT
                || (state_ff == ST_ON && !MAIN_OK_IN); // [RULE7] [RULE21]
    end

    // Pins; open-drain lines only ever pull low, so partners wire-OR [RULE6]
    assign MAIN_EN_OUT = main_en_ff;
    assign VSB_EN_OUT = 1'b1; // [RULE1]
    assign ORING_EN_OUT = main_en_ff && !ctrl_ff[CTRL_STANDBY_BIT];
    assign POWER_GOOD_OUT = 1'b0;
    assign POWER_GOOD_OE_OUT = !pg_ff; // [RULE6]
    assign FAULT_ALERT_N_OUT = 1'b0;
    assign FAULT_ALERT_N_OE_OUT = alert_ff; // [RULE7]
    assign INPUT_OK_OUT = input_ok_ff;
    assign FAN_MAX_OUT = fan_max_ff;

    // APB decode; zero wait states, error on unmapped offsets
    assign addr_ok = (PADDR == ADDR_CTRL) || (PADDR == ADDR_STATUS)
        || (PADDR == ADDR_TEMP) || (PADDR == ADDR_EVENT);
    assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
    assign PRDATA = prdata_ff;

    // Control register
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            ctrl_ff <= CTRL_RESET;
        else if (wr_en && PADDR == ADDR_CTRL)
            ctrl_ff <= PWDATA[1:0];
    end

    // Sticky events, write one to clear; a new event beats the clear
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            event_ff <= 4'h0;
        else
        begin
            if (wr_en && PADDR == ADDR_EVENT)
                event_ff <= event_ff & ~PWDATA[3:0];
            if (SENSE_SHORT_IN)
                event_ff[EV_SENSE_BIT] <= 1'b1;
            if (state_ff == ST_RAMP && nxt_state == ST_FAULT)
                event_ff[EV_RAMP_BIT] <= 1'b1;
            if (!DC_PRESENT_IN)
                event_ff[EV_DCLOSS_BIT] <= 1'b1;
            if (ot_warn_ff)
                event_ff[EV_OTW_BIT] <= 1'b1;
        end
    end

    // Read data captured in setup so it is stable through the access phase
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            prdata_ff <= 32'h0000_0000;
        else if (rd_setup)
        begin
            prdata_ff <= 32'h0000_0000;
            if (PADDR == ADDR_CTRL)
                prdata_ff <= {30'h0000_0000, ctrl_ff};
            else if (PADDR == ADDR_STATUS)
                prdata_ff <= {26'h000_0000, state_ff == ST_FAULT, fan_max_ff, alert_ff,
                    main_en_ff, input_ok_ff, pg_ff};
            else if (PADDR == ADDR_TEMP)
                prdata_ff <= {16'h0000, INLET_TEMP_IN, 7'h00, ot_warn_ff};
            else if (PADDR == ADDR_EVENT)
                prdata_ff <= {28'h000_0000, event_ff};
        end
    end

    // Checks
    chk_kill_main_off: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE1]
        OUTPUT_KILL_IN |=> !MAIN_EN_OUT)
        else $error("main output enabled while kill is high");
    chk_standby_kept: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE1]
        OUTPUT_KILL_IN |-> VSB_EN_OUT)
        else $error("standby output dropped");
    chk_sense_shutdown: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE2]
        SENSE_SHORT_IN |=> state_ff == ST_FAULT ##1 !MAIN_EN_OUT)
        else $error("no shutdown on sense short");
    chk_pg_in_reg: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE3]
        pg_ff |-> $past(MAIN_OK_IN) && $past(VSB_OK_IN) && !POWER_GOOD_OE_OUT)
        else $error("power good without regulation");
    chk_pg_hold_limit: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE5]
        state_ff == ST_PG_DELAY && CUR_LIMIT_IN && nxt_state == ST_PG_DELAY
        |=> ms_cnt_ff == 11'h000)
        else $error("power good timer ran in current limit");
    chk_alert_dc_loss: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE21]
        !DC_PRESENT_IN |=> FAULT_ALERT_N_OE_OUT)
        else $error("alert missing after input loss");
    chk_fan_before_warn: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE9]
        $rose(ot_warn_ff) |-> $past(fan_max_ff) && fan_max_ff)
        else $error("warning set before fan forced to maximum");
    chk_off_hold_time: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE14]
        state_ff == ST_OFF_HOLD && nxt_state != ST_OFF_HOLD && !SENSE_SHORT_IN
        |-> ms_cnt_ff >= OFF_HOLD_MS)
        else $error("off hold left early");
    chk_inok_ov: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE10]
        VIN_OV_IN |=> !INPUT_OK_OUT)
        else $error("input ok high in over-voltage");
    chk_inok_dwell: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE12]
        $rose(input_ok_ff) && $past(dropped_ff) |-> $past(dwell_ms_ff) >= DWELL_MS)
        else $error("input ok returned before dwell");
    chk_pg_holdup: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE22]
        pg_ff && !DC_PRESENT_IN && !holdup_done && !stop_req && MAIN_OK_IN && VSB_OK_IN
        && !SENSE_SHORT_IN |=> pg_ff)
        else $error("power good dropped inside hold-up");
    chk_pg_stop_drop: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE16]
        state_ff == ST_ON && stop_req |=> !pg_ff)
        else $error("power good held after stop request");
    chk_pg_delay_min: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE17]
        $rose(pg_ff) |-> $past(ms_cnt_ff) > PG_ON_MS)
        else $error("power good asserted before its delay");
    chk_start_min_delay: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE15]
        state_ff == ST_START && nxt_state == ST_RAMP |-> ms_cnt_ff > SON_MIN_MS)
        else $error("main output enabled too early");
    chk_fault_alert: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE7]
        state_ff == ST_FAULT |=> FAULT_ALERT_N_OE_OUT)
        else $error("no alert in fault state");
    chk_inok_low: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE12]
        !in_good |=> !INPUT_OK_OUT)
        else $error("input ok high with bad input");
    chk_fan_follows_temp: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // [RULE9]
        INLET_TEMP_IN >= OT_WARN_DEGC |=> FAN_MAX_OUT)
        else $error("fan not forced at warning temperature");

    // Cover points for the main scenarios
    cov_sense_fault: cover property (@(posedge CLK_IN) $rose(state_ff == ST_FAULT));
    cov_turn_on: cover property (@(posedge CLK_IN) $rose(pg_ff));
    cov_dwell_back: cover property (@(posedge CLK_IN) $rose(input_ok_ff) && dropped_ff);
    cov_ot_warn: cover property (@(posedge CLK_IN) $rose(ot_warn_ff));
    cov_ramp_fault: cover property (@(posedge CLK_IN) event_ff[EV_RAMP_BIT]);
endmodule : pss_sequencer
`default_nettype wire

// ### sim/pss_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pss_host_model
#(
    parameter int RISE = 20
)
(
    input wire logic clk_in,
    input wire logic main_en_in,
    input wire logic vsb_en_in,
    input wire logic pg_val_in,
    input wire logic pg_oe_in,
    input wire logic alert_val_in,
    input wire logic alert_oe_in,
    output logic vsb_ok_out,
    output logic main_ok_out,
    output logic pg_line_out,
    output logic alert_line_out
);
    int rise_ff = 0;
    // Main rail needs RISE cycles to settle but drops at the first clock edge after it is disabled
    always_ff @(posedge clk_in)
        rise_ff <= main_en_in ? ((rise_ff < RISE) ? rise_ff + 1 : rise_ff) : 0;
    assign main_ok_out = (rise_ff == RISE);
    assign vsb_ok_out = vsb_en_in;
    // Shared lines sit at the pull-up unless a supply drives them
    assign pg_line_out = pg_oe_in ? pg_val_in : 1'h1;
    assign alert_line_out = alert_oe_in ? alert_val_in : 1'h1;
endmodule : pss_host_model
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import pss_pkg::*;;
    logic clk = 0;
    logic rst = 1;
    logic psel = 0;
    logic pen = 0;
    logic pwr = 0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic kill = 0;
    logic son_n = 1;
    logic dc = 1;
    logic vov = 0;
    logic vlow = 0;
    logic otemp = 0;
    logic climit = 0;
    logic sshort = 0;
    logic [7:0] temp = 8'h19;
    logic fan_at = 0;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, main_en, vsb_en, oring, pg_o, pg_oe, al_o, al_oe;
    logic in_ok, fan_max, vsb_ok, main_ok, pg_line, alert_line;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int n, t0, td;
    // Short tick and holdup keep the second-long windows affordable
    pss_sequencer #(.TICK_CYCLES(10), .HOLDUP_CYCLES(4)) dut (
        .CLK_IN(clk), .RESET_IN(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .OUTPUT_KILL_IN(kill), .SUPPLY_ON_N_IN(son_n),
        .DC_PRESENT_IN(dc), .VIN_LOW_IN(vlow), .VIN_OV_IN(vov), .VSB_OK_IN(vsb_ok),
        .MAIN_OK_IN(main_ok), .CUR_LIMIT_IN(climit), .SENSE_SHORT_IN(sshort),
        .OVER_TEMP_IN(otemp), .INLET_TEMP_IN(temp), .FAN_AT_MAX_IN(fan_at),
        .MAIN_EN_OUT(main_en), .VSB_EN_OUT(vsb_en), .ORING_EN_OUT(oring),
        .POWER_GOOD_OUT(pg_o), .POWER_GOOD_OE_OUT(pg_oe), .FAULT_ALERT_N_OUT(al_o),
        .FAULT_ALERT_N_OE_OUT(al_oe), .INPUT_OK_OUT(in_ok), .FAN_MAX_OUT(fan_max));
    pss_host_model host (.clk_in(clk), .main_en_in(main_en), .vsb_en_in(vsb_en),
        .pg_val_in(pg_o), .pg_oe_in(pg_oe), .alert_val_in(al_o), .alert_oe_in(al_oe),
        .vsb_ok_out(vsb_ok), .main_ok_out(main_ok), .pg_line_out(pg_line),
        .alert_line_out(alert_line));
    // Clock and a cycle count on the falling edge, so reads at the rising edge never race
    always #12.5 clk = ~clk;
    always @(negedge clk) cyc <= cyc + 1;
    function automatic logic sig(input int s);
        case (s)
            0: return main_en;
            1: return pg_line;
            2: return alert_line;
            3: return in_ok;
            4: return fan_max;
            5: return main_ok;
            6: return oring;
            default: return vsb_en;
        endcase
    endfunction : sig
    task final_report();
        $display("Checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Samples on the falling edge and hands back at a rising edge for the next drive
    task pk(input int s, input logic v);
        @(negedge clk);
        chk($sformatf("signal %0d", s), sig(s), v);
        @(posedge clk);
    endtask : pk
    // Bounded wait; n is the count of falling edges until the level appeared
    task wt(input int s, input logic v, input int lim);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (sig(s) !== v && n < lim);
        if (sig(s) !== v)
        begin
            $display("CHECK FAILED wait %0d expected %b seen %b", s, v, sig(s));
            bad_count++;
            final_report();
        end
        @(posedge clk);
    endtask : wt
    // One APB transfer; request held until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        @(posedge clk);
        for (i = 0; i < 16 && pready !== 1'h1; i++)
            @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
        if (pready !== 1'h1)
        begin
            $display("CHECK FAILED pready expected 1 seen %b", pready);
            bad_count++;
            final_report();
        end
    endtask : apb
    // Restart after an off event: off-hold first, then the power-good delay
    task reon(input int t);
        wt(0, 1, 11000);
        chk("off hold", cyc - t >= 9995, 1);
        wt(5, 1, 100);
        wt(1, 1, 1100);
        chk("pg low time", cyc - t >= 1000, 1);
    endtask : reon
    task t_regs();
        apb(0, ADDR_CTRL, 32'h0);
        chk("ctrl reset", q, 32'h1);
        apb(1, 8'h10, 32'hF);
        chk("unmapped err", {31'h0, e}, 32'h1);
        apb(0, 8'h10, 32'h0);
        chk("unmapped data", q, 32'h0);
        $display("register test done");
    endtask : t_regs
    task t_up();
        wt(3, 1, 200);
        son_n <= 1'h0;
        climit <= 1'h1;
        wt(0, 1, 4000);
        chk("main delay", n >= 48, 1);
        chk("vsb to main", cyc >= 498, 1);
        wt(5, 1, 100);
        wt(2, 0, 4);
        repeat (300) @(posedge clk);
        pk(1, 0);
        climit <= 1'h0;
        wt(1, 1, 1100);
        chk("pg delay", n >= 998 && n <= 1015, 1);
        wt(2, 1, 4);
        apb(0, ADDR_STATUS, 32'h0);
        chk("status pg", q[0], 1);
        apb(1, ADDR_CTRL, 32'h3);
        pk(6, 0);
        apb(1, ADDR_CTRL, 32'h1);
        pk(6, 1);
        $display("power up test done");
    endtask : t_up
    task t_temp();
        temp <= 8'h3B;
        repeat (3) @(posedge clk);
        pk(4, 0);
        temp <= 8'h3C;
        wt(4, 1, 3);
        repeat (5) @(posedge clk);
        apb(0, ADDR_TEMP, 32'h0);
        chk("warn before fan", q[0], 0);
        fan_at <= 1'h1;
        repeat (3) @(posedge clk);
        apb(0, ADDR_TEMP, 32'h0);
        chk("warn set", q[15:0], 32'h3C01);
        pk(2, 0);
        temp <= 8'h3B;
        fan_at <= 1'h0;
        repeat (3) @(posedge clk);
        apb(0, ADDR_TEMP, 32'h0);
        chk("warn clear", q[15:0], 32'h3B00);
        wt(2, 1, 4);
        otemp <= 1'h1;
        wt(2, 0, 4);
        otemp <= 1'h0;
        wt(2, 1, 4);
        $display("temperature test done");
    endtask : t_temp
    task t_dc();
        dc <= 1'h0;
        t0 = cyc;
        wt(2, 0, 20);
        wt(1, 0, 40);
        chk("pg holdup", cyc - t0 >= 4, 1);
        td = cyc;
        pk(3, 0);
        dc <= 1'h1;
        wt(3, 1, 1200);
        chk("input dwell", n >= 750, 1);
        reon(td);
        $display("input loss test done");
    endtask : t_dc
    task t_son();
        son_n <= 1'h1;
        wt(1, 0, 50);
        td = cyc;
        pk(0, 0);
        son_n <= 1'h0;
        reon(td);
        $display("supply on test done");
    endtask : t_son
    task t_kill();
        kill <= 1'h1;
        wt(0, 0, 4);
        pk(7, 1);
        wt(1, 0, 40);
        td = cyc;
        kill <= 1'h0;
        reon(td);
        $display("kill test done");
    endtask : t_kill
    task t_short();
        sshort <= 1'h1;
        wt(0, 0, 4);
        wt(2, 0, 4);
        vov <= 1'h1;
        wt(3, 0, 3);
        vov <= 1'h0;
        wt(3, 1, 1200);
        vlow <= 1'h1;
        wt(3, 0, 3);
        apb(0, ADDR_EVENT, 32'h0);
        chk("sense event", q[EV_SENSE_BIT], 1);
        apb(0, ADDR_STATUS, 32'h0);
        chk("fault state", q[5], 1);
        sshort <= 1'h0;
        vlow <= 1'h0;
        apb(1, ADDR_EVENT, 32'hF);
        apb(0, ADDR_EVENT, 32'h0);
        chk("event clear", q[3:0], 32'h0);
        $display("sense short test done");
    endtask : t_short
    // Main sequence; every wait inside is bounded and reports on overrun
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_regs();
        t_up();
        t_temp();
        t_dc();
        t_son();
        t_kill();
        t_short();
        final_report();
    end
endmodule : tb
`default_nettype wire
